// [include/sub_alu_pkg.sv]
package sub_alu_pkg;
    // ------------------------------------------------------------
    // Widths and address map
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int ADDR_W = 12;
    localparam int BANK_W = 4;
    localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [BANK_W-1:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hf;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [4:0] FLAGS_RESET = 5'h00;
    // ------------------------------------------------------------
    // Flag positions: negative, overflow, zero, digit carry, carry
    // ------------------------------------------------------------
    localparam int FLAG_C = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_N = 4;
    typedef enum logic [1:0] {
        OP_NONE,
        OP_SUB_LITERAL,
        OP_SUB_REGISTER
    } sub_op_type;
endpackage : sub_alu_pkg

// [hdl/sub_core.sv]
`timescale 1ns/10ps
// Two's complement subtract a - b with status flags
module sub_core
    import sub_alu_pkg::*;
(
    input wire logic [7:0] minuend_i,
    input wire logic [7:0] subtrahend_i,
    output logic [7:0] diff_o,
    output logic [4:0] flags_o
);
    // ------------------------------------------------------------
    // Add inverted subtrahend plus one; carry set means no borrow
    // ------------------------------------------------------------
    wire logic [8:0] full_sum;
    wire logic [4:0] nib_sum;
    assign full_sum = {1'b0, minuend_i} + {1'b0, ~subtrahend_i} + 9'h001;
    assign nib_sum = {1'b0, minuend_i[3:0]} + {1'b0, ~subtrahend_i[3:0]} + 5'h01;
    assign diff_o = full_sum[7:0];
    assign flags_o[FLAG_C] = full_sum[8];
    assign flags_o[FLAG_DC] = nib_sum[4];
    assign flags_o[FLAG_Z] = (full_sum[7:0] == 8'h00);
    assign flags_o[FLAG_OV] = (minuend_i[7] != subtrahend_i[7]) &&
                              (full_sum[7] != minuend_i[7]);
    assign flags_o[FLAG_N] = full_sum[7];
endmodule : sub_core

// [hdl/subtract_from_accumulator_alu.sv]
`timescale 1ns/10ps
module subtract_from_accumulator_alu
    import sub_alu_pkg::*;
(
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic issue_i,
    input wire logic sel_register_i,
    input wire logic [7:0] literal_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic dest_reg_i,
    input wire logic bank_mode_i,
    input wire logic extended_en_i,
    input wire logic [BANK_W-1:0] bank_pointer_reg_i,
    input wire logic [ADDR_W-1:0] index_base_i,
    input wire logic [7:0] reg_rdata_i,
    output logic [ADDR_W-1:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_we_o,
    output logic [7:0] acc_o,
    output logic [4:0] flags_o,
    output logic done_o
);
    // ------------------------------------------------------------
    // Operand address forming
    // ------------------------------------------------------------
    wire logic indexed_mode;
    wire logic [ADDR_W-1:0] indexed_addr;
    wire logic [ADDR_W-1:0] access_addr;
    wire logic [ADDR_W-1:0] banked_addr;
    wire logic [ADDR_W-1:0] operand_addr;
    assign indexed_mode = extended_en_i && !bank_mode_i && (reg_addr_i <= INDEXED_LIMIT);
    // Base plus offset wraps at 12 bits; keeping the base in range is up to the program
    assign indexed_addr = index_base_i + {4'h0, reg_addr_i};
    // Low part of direct bank maps to bank 0, upper part to the top bank
    assign access_addr = (reg_addr_i < ACCESS_SPLIT) ? {ACCESS_LOW_BANK, reg_addr_i}
                                                     : {ACCESS_HIGH_BANK, reg_addr_i};
    assign banked_addr = {bank_pointer_reg_i, reg_addr_i};
    // Indexed mode wins; with bank bit 1 it can never be active
    assign operand_addr = indexed_mode ? indexed_addr :
                          (bank_mode_i ? banked_addr : access_addr);

    // ------------------------------------------------------------
    // Two-cycle sequence: address out, then read data back and write
    // ------------------------------------------------------------
    logic pending_reg;
    logic pend_dest_reg;
    logic [ADDR_W-1:0] pend_addr_reg;
    logic [7:0] acc_reg;
    logic [4:0] flags_reg;
    logic [7:0] wdata_reg;
    logic we_reg;
    logic done_reg;
    wire logic [7:0] minuend;
    wire logic [7:0] diff;
    wire logic [4:0] diff_flags;
    wire logic literal_go;
    wire logic register_go;
    // Register data is taken only in the second cycle, after the address settled
    assign minuend = pending_reg ? reg_rdata_i : literal_i;
    assign literal_go = issue_i && !sel_register_i && !pending_reg;
    assign register_go = issue_i && sel_register_i && !pending_reg;

    sub_core u_sub_core (
        .minuend_i(minuend),
        .subtrahend_i(acc_reg),
        .diff_o(diff),
        .flags_o(diff_flags)
    );

    // Request capture; issues while busy are ignored
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pending_reg <= 1'b0;
            pend_dest_reg <= 1'b0;
            pend_addr_reg <= '0;
        end else begin
            pending_reg <= register_go;
            if (register_go) begin
                pend_dest_reg <= dest_reg_i;
                pend_addr_reg <= operand_addr;
            end
        end
    end

    // Result write: accumulator or register, flags always
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            acc_reg <= ACC_RESET;
            flags_reg <= FLAGS_RESET;
            wdata_reg <= 8'h00;
            we_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            // Write strobe pulses for one cycle, done stays high across back-to-back literals; both rebuilt every edge
            we_reg <= pending_reg && pend_dest_reg;
            done_reg <= literal_go || pending_reg;
            // Flags follow both instructions, whatever the destination
            if (literal_go || pending_reg) begin
                flags_reg <= diff_flags;
            end
            if (literal_go || (pending_reg && !pend_dest_reg)) begin
                acc_reg <= diff;
            end
            if (pending_reg && pend_dest_reg) begin
                wdata_reg <= diff;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs, each taken straight from a register
    // ------------------------------------------------------------
    assign reg_addr_o = pend_addr_reg;
    assign reg_wdata_o = wdata_reg;
    assign reg_we_o = we_reg;
    assign acc_o = acc_reg;
    assign flags_o = flags_reg;
    assign done_o = done_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    sequence reg_issue_s;
        issue_i && sel_register_i && !pending_reg;
    endsequence
    sequence dest_acc_s;
        reg_issue_s ##0 !dest_reg_i;
    endsequence

    reg_diff_a: assert property (pending_reg && pend_dest_reg |=>
        reg_wdata_o == 8'($past(reg_rdata_i) - $past(acc_reg)))
        else $error("register difference wrong");
    dest_acc_a: assert property (dest_acc_s |-> ##2 !reg_we_o)
        else $error("register written with accumulator destination");
    dest_acc_val_a: assert property (pending_reg && !pend_dest_reg |=>
        acc_o == 8'($past(reg_rdata_i) - $past(acc_o)))
        else $error("accumulator difference wrong");
    dest_reg_a: assert property (reg_issue_s ##0 dest_reg_i |-> ##2 reg_we_o)
        else $error("register write missing");
    dest_reg_acc_a: assert property (pending_reg && pend_dest_reg |=> $stable(acc_o))
        else $error("accumulator changed on register destination");
    // Direct bank ignores the pointer: low part in bank 0, the rest in the top bank
    access_bank_a: assert property (reg_issue_s ##0 (!bank_mode_i && !indexed_mode) |=>
        reg_addr_o[7:0] == $past(reg_addr_i) &&
        reg_addr_o[11:8] == (($past(reg_addr_i) < ACCESS_SPLIT) ? ACCESS_LOW_BANK
                                                                 : ACCESS_HIGH_BANK))
        else $error("direct bank address wrong");
    banked_a: assert property (reg_issue_s ##0 bank_mode_i |=>
        reg_addr_o == {$past(bank_pointer_reg_i), $past(reg_addr_i)})
        else $error("banked address wrong");
    indexed_a: assert property (reg_issue_s ##0 indexed_mode |=>
        reg_addr_o == 12'($past(index_base_i) + {4'h0, $past(reg_addr_i)}))
        else $error("indexed address wrong");
    literal_a: assert property (literal_go |=>
        acc_o == 8'($past(literal_i) - $past(acc_o)) && done_o
        && flags_o[FLAG_Z] == (acc_o == 8'h00))
        else $error("literal subtract wrong");

    // ------------------------------------------------------------
    // Sequencing, strobes and flags
    // ------------------------------------------------------------
    // Register subtract commits on its second edge, never on the first
    sequence reg_commit_s;
        !done_o ##1 done_o;
    endsequence
    sequence lit_issue_s;
        issue_i && !sel_register_i && !pending_reg;
    endsequence

    reg_commit_a: assert property (reg_issue_s |=> reg_commit_s)
        else $error("register subtract did not commit on time");
    // A second issue in the busy cycle is dropped, not queued
    busy_drop_a: assert property (pending_reg |=> !pending_reg)
        else $error("request taken while busy");
    // Address must not move while the read data is in use
    addr_hold_a: assert property (pending_reg |=> $stable(reg_addr_o))
        else $error("operand address moved during access");
    // Carry means no borrow, digit carry likewise on the low nibble
    reg_carry_a: assert property (pending_reg |=>
        flags_o[FLAG_C] == ($past(reg_rdata_i) >= $past(acc_reg))
        && flags_o[FLAG_DC] == ($past(reg_rdata_i[3:0]) >= $past(acc_reg[3:0])))
        else $error("register carry flags wrong");
    keep_source_a: assert property (pending_reg && !pend_dest_reg |=> !reg_we_o)
        else $error("source register written with accumulator destination");
    // Idle cycles must leave the accumulator alone
    acc_hold_a: assert property (!literal_go && !pending_reg |=> $stable(acc_o))
        else $error("accumulator changed without a result");
    // Write strobe never stretches; the sink counts one write per pulse
    we_pulse_a: assert property (reg_we_o |=> !reg_we_o)
        else $error("write strobe longer than one cycle");
    // Write data only moves when a register result lands
    wdata_hold_a: assert property (!pending_reg |=> $stable(reg_wdata_o))
        else $error("write data changed without a result");
    // Bank bit 1 must never fall back to the direct bank or indexed offsets
    banked_no_index_a: assert property (reg_issue_s ##0 bank_mode_i |=>
        reg_addr_o[11:8] == $past(bank_pointer_reg_i))
        else $error("banked access used another bank");
    lit_carry_a: assert property (lit_issue_s |=>
        flags_o[FLAG_C] == ($past(literal_i) >= $past(acc_o))
        && flags_o[FLAG_DC] == ($past(literal_i[3:0]) >= $past(acc_o[3:0])))
        else $error("literal carry flags wrong");
    lit_sign_a: assert property (lit_issue_s |=>
        flags_o[FLAG_N] == acc_o[7] && !reg_we_o)
        else $error("literal sign flag or write strobe wrong");
    // Overflow only when the operand signs differ and the result sign flips
    lit_ovf_a: assert property (lit_issue_s |=>
        flags_o[FLAG_OV] == (($past(literal_i[7]) != $past(acc_o[7]))
        && (acc_o[7] != $past(literal_i[7]))))
        else $error("literal overflow flag wrong");
    // No request, no strobes
    idle_quiet_a: assert property (!issue_i && !pending_reg |=> !done_o && !reg_we_o)
        else $error("strobe without a request");
endmodule : subtract_from_accumulator_alu

// [tb/subtract_from_accumulator_alu_bench.sv]
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %0t got %h want %h", $time, g, e); end end
// ------------------------------------------------------------
// Bench for the subtract datapath
// ------------------------------------------------------------
module subtract_from_accumulator_alu_bench
    import sub_alu_pkg::*;
;
    logic mclk_i = 0, reset_n_i = 0, issue_i = 0, sel_register_i = 0;
    logic dest_reg_i = 0, bank_mode_i = 0, extended_en_i = 0, reg_we_o, done_o;
    logic [7:0] literal_i = 0, reg_addr_i = 0, reg_rdata_i = 0, reg_wdata_o, acc_o, m_acc;
    logic [3:0] bank_pointer_reg_i = 0;
    logic [11:0] index_base_i = 12'h2a4, reg_addr_o;
    logic [4:0] flags_o;
    int n_mismatch = 0, total_checks = 0;
    subtract_from_accumulator_alu u_dut (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .issue_i(issue_i),
        .sel_register_i(sel_register_i), .literal_i(literal_i), .reg_addr_i(reg_addr_i),
        .dest_reg_i(dest_reg_i), .bank_mode_i(bank_mode_i), .extended_en_i(extended_en_i),
        .bank_pointer_reg_i(bank_pointer_reg_i), .index_base_i(index_base_i),
        .reg_rdata_i(reg_rdata_i), .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o),
        .reg_we_o(reg_we_o), .acc_o(acc_o), .flags_o(flags_o), .done_o(done_o)
    );
    // Free-running clock, 5 ns period
    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end
    // Expected flags of a - b; carry means no borrow
    function automatic logic [4:0] ef(input logic [7:0] a, b);
        logic [7:0] d;
        logic [4:0] r;
        d = a - b;
        r = '0;
        r[FLAG_C] = a >= b;
        r[FLAG_DC] = a[3:0] >= b[3:0];
        r[FLAG_Z] = d == 8'h00;
        r[FLAG_N] = d[7];
        r[FLAG_OV] = (a[7] ^ b[7]) & (d[7] ^ a[7]);
        return r;
    endfunction : ef
    // Expected operand address from bank bit, extended mode and pointer
    function automatic logic [11:0] ea(input logic [7:0] f, input logic a, x, input logic [3:0] b);
        if (a) return {b, f};
        if (x && f <= INDEXED_LIMIT) return index_base_i + {4'h0, f};
        return {(f < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK, f};
    endfunction : ea
    task automatic do_lit(input logic [7:0] k);
        @(negedge mclk_i) {issue_i, sel_register_i, literal_i} = {2'b10, k};
        // Done stands for one cycle only, so look at once
        @(negedge mclk_i) issue_i = 0;
        `CHK(done_o, 1'b1)
        `CHK(reg_we_o, 1'b0)
        `CHK(flags_o, ef(k, m_acc))
        m_acc = k - m_acc;
        `CHK(acc_o, m_acc)
    endtask : do_lit
    task automatic do_reg(input logic [7:0] f, rd, input logic d, a, x, input logic [3:0] b);
        logic [7:0] dif;
        dif = rd - m_acc;
        @(negedge mclk_i) {issue_i, sel_register_i, reg_addr_i} = {2'b11, f};
        {dest_reg_i, bank_mode_i, extended_en_i, bank_pointer_reg_i} = {d, a, x, b};
        reg_rdata_i = ~rd;
        @(negedge mclk_i) issue_i = 0;
        // Address is out now; read data must stand at the very next edge
        reg_rdata_i = rd;
        `CHK(reg_addr_o, ea(f, a, x, b))
        @(negedge mclk_i) reg_rdata_i = ~rd;
        `CHK(done_o, 1'b1)
        `CHK(flags_o, ef(rd, m_acc))
        `CHK(reg_we_o, d)
        if (d) `CHK(reg_wdata_o, dif)
        if (!d) m_acc = dif;
        `CHK(acc_o, m_acc)
    endtask : do_reg
    task automatic scn_literal();
        logic [7:0] ks[8] = '{8'h01, 8'h02, 8'h03, 8'h02, 8'h03, 8'h02, 8'h80, 8'h7f};
        `CHK(acc_o, ACC_RESET)
        `CHK(flags_o, FLAGS_RESET)
        foreach (ks[i]) do_lit(ks[i]);
    endtask : scn_literal
    task automatic scn_dest();
        do_reg(8'h33, 8'h03, 1'b1, 1'b1, 1'b0, 4'h3);
        do_reg(8'h34, 8'h90, 1'b0, 1'b1, 1'b0, 4'h2);
        do_reg(8'h35, m_acc, 1'b0, 1'b1, 1'b0, 4'h2);
    endtask : scn_dest
    task automatic scn_bank();
        logic [7:0] fs[5] = '{8'h20, 8'h60, 8'h5f, 8'h60, 8'h5f};
        logic [2:0] ax[5] = '{3'b000, 3'b000, 3'b001, 3'b001, 3'b111};
        foreach (fs[i]) do_reg(fs[i], 8'(8'h4c + i), ax[i][2], ax[i][1], ax[i][0],
                               4'(4'h5 + i));
    endtask : scn_bank
    // Single closing point for both normal end and watchdog
    task automatic print_verdict();
        if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    // Run is about 40 cycles after reset; watchdog allows far more
    initial begin
        #20000 n_mismatch++;
        print_verdict();
    end
    initial begin
        m_acc = ACC_RESET;
        repeat (16) @(negedge mclk_i);
        reset_n_i = 1;
        scn_literal();
        scn_dest();
        scn_bank();
        print_verdict();
    end
endmodule : subtract_from_accumulator_alu_bench
